// ===== design/embedded_block_ram_defines.svh
// constants for the embedded block ram tile
`ifndef EMBEDDED_BLOCK_RAM_DEFINES_SVH
`define EMBEDDED_BLOCK_RAM_DEFINES_SVH

// ---------------------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------------------
`define ARRAY_BITS     9216
`define ADDR_W         13
`define DATA_W         36
`define BIT_IDX_W      14
`define INIT_ADDR_W    8
`define INIT_WORD_BITS 36

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define RST_DATA       36'h0_0000_0000
`define RST_VALID      1'h0

`endif

// ===== design/embedded_block_ram_pkg.sv
// types shared by the embedded block ram tile
`include "embedded_block_ram_defines.svh"

package embedded_block_ram_pkg;

  // -------------------------------------------------------------------------
  // modes and shapes
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_TRUE_DUAL,
    MODE_PSEUDO_DUAL
  } mode_e;

  typedef enum logic [2:0] {
    W1,
    W2,
    W4,
    W9,
    W18,
    W36
  } width_e;

  // -------------------------------------------------------------------------
  // request carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic                 we;
    logic                 re;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   data;
  } port_req_s;

  typedef struct packed {
    logic                     we;
    logic [`INIT_ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]       data;
  } init_req_s;

endpackage

// ===== design/ram_port_pipe.sv
// input registers and optional output register of one ram port
`timescale 1ns/1ps
`include "embedded_block_ram_defines.svh"

module ram_port_pipe (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire embedded_block_ram_pkg::port_req_s req,
  input  wire logic                              out_reg_en,
  input  wire logic [`DATA_W-1:0]                rd_word,
  output      embedded_block_ram_pkg::port_req_s req_q,
  output      logic [`DATA_W-1:0]                dout,
  output      logic                              dout_valid
);

  embedded_block_ram_pkg::port_req_s req_q_r;
  logic [`DATA_W-1:0]                arr_q_r;
  logic                              arr_v_r;
  logic [`DATA_W-1:0]                dout_r;
  logic                              valid_r;

  // -------------------------------------------------------------------------
  // input capture
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_q_r <= '0;
    end else begin
      req_q_r <= req;
    end
  end

  // -------------------------------------------------------------------------
  // read pipeline
  // -------------------------------------------------------------------------
  // switching out_reg_en with reads in flight may drop or repeat one word
  always_ff @(posedge core_clk) begin
    if (reset) begin
      arr_q_r <= `RST_DATA;
      arr_v_r <= `RST_VALID;
    end else begin
      arr_q_r <= rd_word;
      arr_v_r <= req_q_r.re;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dout_r  <= `RST_DATA;
      valid_r <= `RST_VALID;
    end else if (out_reg_en) begin
      valid_r <= arr_v_r;
      if (arr_v_r) begin
        dout_r <= arr_q_r;
      end
    end else begin
      valid_r <= req_q_r.re;
      if (req_q_r.re) begin
        dout_r <= rd_word;
      end
    end
  end

  assign req_q      = req_q_r;
  assign dout       = dout_r;
  assign dout_valid = valid_r;

endmodule

// ===== design/embedded_block_ram.sv
// 9-kbit block ram tile with single, true dual and pseudo dual port modes
`timescale 1ns/1ps
`include "embedded_block_ram_defines.svh"

module embedded_block_ram (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire embedded_block_ram_pkg::mode_e     mode,
  input  wire embedded_block_ram_pkg::width_e    width_a,
  input  wire embedded_block_ram_pkg::width_e    width_b,
  input  wire logic                              out_reg_a,
  input  wire logic                              out_reg_b,
  input  wire logic                              cfg_load,
  input  wire embedded_block_ram_pkg::init_req_s init,
  input  wire embedded_block_ram_pkg::port_req_s port_a,
  input  wire embedded_block_ram_pkg::port_req_s port_b,
  output      logic [`DATA_W-1:0]                dout_a,
  output      logic                              valid_a,
  output      logic [`DATA_W-1:0]                dout_b,
  output      logic                              valid_b
);

  // -------------------------------------------------------------------------
  // shape decoding
  // -------------------------------------------------------------------------
  function automatic logic [5:0] width_bits(
    input embedded_block_ram_pkg::width_e w
  );
    unique case (w)
      embedded_block_ram_pkg::W1:  width_bits = 6'h01;
      embedded_block_ram_pkg::W2:  width_bits = 6'h02;
      embedded_block_ram_pkg::W4:  width_bits = 6'h04;
      embedded_block_ram_pkg::W9:  width_bits = 6'h09;
      embedded_block_ram_pkg::W18: width_bits = 6'h12;
      embedded_block_ram_pkg::W36: width_bits = 6'h24;
      default:                     width_bits = 6'h01;
    endcase
  endfunction

  function automatic logic [`ADDR_W-1:0] depth_mask(
    input embedded_block_ram_pkg::width_e w
  );
    unique case (w)
      embedded_block_ram_pkg::W1:  depth_mask = 13'h1fff;
      embedded_block_ram_pkg::W2:  depth_mask = 13'h0fff;
      embedded_block_ram_pkg::W4:  depth_mask = 13'h07ff;
      embedded_block_ram_pkg::W9:  depth_mask = 13'h03ff;
      embedded_block_ram_pkg::W18: depth_mask = 13'h01ff;
      embedded_block_ram_pkg::W36: depth_mask = 13'h00ff;
      default:                     depth_mask = 13'h1fff;
    endcase
  endfunction

  // out-of-range address bits are dropped, so an index never leaves the array
  function automatic logic [`BIT_IDX_W-1:0] bit_base(
    input logic [`ADDR_W-1:0]           addr,
    input embedded_block_ram_pkg::width_e w
  );
    logic [`BIT_IDX_W-1:0] word;
    logic [`BIT_IDX_W-1:0] wide;
    word     = {1'b0, addr & depth_mask(w)};
    wide     = {8'h00, width_bits(w)};
    bit_base = `BIT_IDX_W'(word * wide);
  endfunction

  // true dual has no 36-bit shape; 512x18 is the nearest legal one
  function automatic embedded_block_ram_pkg::width_e clamp_width(
    input embedded_block_ram_pkg::mode_e  m,
    input embedded_block_ram_pkg::width_e w
  );
    if (m == embedded_block_ram_pkg::MODE_TRUE_DUAL &&
        w == embedded_block_ram_pkg::W36) begin
      clamp_width = embedded_block_ram_pkg::W18;
    end else begin
      clamp_width = w;
    end
  endfunction

  // -------------------------------------------------------------------------
  // mode gating of user requests
  // -------------------------------------------------------------------------
  embedded_block_ram_pkg::port_req_s req_a;
  embedded_block_ram_pkg::port_req_s req_b;
  embedded_block_ram_pkg::port_req_s q_a;
  embedded_block_ram_pkg::port_req_s q_b;
  embedded_block_ram_pkg::width_e    eff_w_a;
  embedded_block_ram_pkg::width_e    eff_w_b;

  // user traffic is shut out while the array is being preloaded
  always_comb begin
    req_a = port_a;
    req_b = port_b;
    unique case (mode)
      embedded_block_ram_pkg::MODE_SINGLE: begin
        req_b.we = 1'b0;
        req_b.re = 1'b0;
      end
      embedded_block_ram_pkg::MODE_TRUE_DUAL: begin
      end
      embedded_block_ram_pkg::MODE_PSEUDO_DUAL: begin
        req_a.re = 1'b0;
        req_b.we = 1'b0;
      end
      // illegal mode codes shut both ports
      default: begin
        req_a.we = 1'b0;
        req_a.re = 1'b0;
        req_b.we = 1'b0;
        req_b.re = 1'b0;
      end
    endcase
    if (cfg_load) begin
      req_a.we = 1'b0;
      req_a.re = 1'b0;
      req_b.we = 1'b0;
      req_b.re = 1'b0;
    end
  end

  // shape follows the live width inputs; change them only when idle
  assign eff_w_a = clamp_width(mode, width_a);
  assign eff_w_b = clamp_width(mode, width_b);

  // -------------------------------------------------------------------------
  // port pipelines
  // -------------------------------------------------------------------------
  logic [`DATA_W-1:0] rd_a;
  logic [`DATA_W-1:0] rd_b;

  ram_port_pipe u_pipe_a (
    .core_clk   (core_clk),
    .reset      (reset),
    .req        (req_a),
    .out_reg_en (out_reg_a),
    .rd_word    (rd_a),
    .req_q      (q_a),
    .dout       (dout_a),
    .dout_valid (valid_a)
  );

  ram_port_pipe u_pipe_b (
    .core_clk   (core_clk),
    .reset      (reset),
    .req        (req_b),
    .out_reg_en (out_reg_b),
    .rd_word    (rd_b),
    .req_q      (q_b),
    .dout       (dout_b),
    .dout_valid (valid_b)
  );

  // -------------------------------------------------------------------------
  // storage array
  // -------------------------------------------------------------------------
  logic [`ARRAY_BITS-1:0] mem_r;
  logic [`BIT_IDX_W-1:0]  base_a;
  logic [`BIT_IDX_W-1:0]  base_b;
  logic [`BIT_IDX_W-1:0]  base_init;
  logic [5:0]             wb_a;
  logic [5:0]             wb_b;

  assign base_a    = bit_base(q_a.addr, eff_w_a);
  assign base_b    = bit_base(q_b.addr, eff_w_b);
  assign base_init = `BIT_IDX_W'({6'h00, init.addr} * `INIT_WORD_BITS);
  assign wb_a      = width_bits(eff_w_a);
  assign wb_b      = width_bits(eff_w_b);

  // contents survive reset, so a preloaded image stays readable as a rom
  // port a is applied last and wins a same-bit collision with port b
  // init writes still act in reset; user writes wait for release
  always_ff @(posedge core_clk) begin
    if (cfg_load && init.we) begin
      for (int i = 0; i < `INIT_WORD_BITS; i++) begin
        mem_r[base_init + `BIT_IDX_W'(i)] <= init.data[i];
      end
    end else if (!reset) begin
      for (int i = 0; i < `DATA_W; i++) begin
        if (q_b.we && 6'(i) < wb_b) begin
          mem_r[base_b + `BIT_IDX_W'(i)] <= q_b.data[i];
        end
      end
      for (int i = 0; i < `DATA_W; i++) begin
        if (q_a.we && 6'(i) < wb_a) begin
          mem_r[base_a + `BIT_IDX_W'(i)] <= q_a.data[i];
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // array read
  // -------------------------------------------------------------------------
  // read returns the old contents when the same port writes the same word
  // bits above the port width stay zero, so narrow reads need no masking
  always_comb begin
    rd_a = `RST_DATA;
    for (int i = 0; i < `DATA_W; i++) begin
      if (6'(i) < wb_a) begin
        rd_a[i] = mem_r[base_a + `BIT_IDX_W'(i)];
      end
    end
  end

  always_comb begin
    rd_b = `RST_DATA;
    for (int i = 0; i < `DATA_W; i++) begin
      if (6'(i) < wb_b) begin
        rd_b[i] = mem_r[base_b + `BIT_IDX_W'(i)];
      end
    end
  end

endmodule

// ===== verif/ram_props.sv
// concurrent checks on the block ram tile ports
`timescale 1ns/1ps
`include "embedded_block_ram_defines.svh"

module ram_props (
  input wire logic                              core_clk,
  input wire logic                              reset,
  input wire embedded_block_ram_pkg::mode_e     mode,
  input wire logic                              out_reg_a,
  input wire logic                              out_reg_b,
  input wire logic                              cfg_load,
  input wire embedded_block_ram_pkg::port_req_s port_a,
  input wire embedded_block_ram_pkg::port_req_s port_b,
  input wire logic [`DATA_W-1:0]                dout_a,
  input wire logic                              valid_a,
  input wire logic                              valid_b
);
  // ---------------------------------------------------------------
  // accepted reads
  // ---------------------------------------------------------------
  wire ok = !reset && !cfg_load;
  wire rd_a = ok && port_a.re
    && mode < embedded_block_ram_pkg::MODE_PSEUDO_DUAL;
  wire rd_b = ok && port_b.re
    && (mode == embedded_block_ram_pkg::MODE_TRUE_DUAL
    || mode == embedded_block_ram_pkg::MODE_PSEUDO_DUAL);

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_rd_a_direct: assert property (rd_a ##1 !out_reg_a |=> valid_a)
    else $error("port a bypass read late");
  a_rd_a_reg: assert property (rd_a ##2 out_reg_a |=> valid_a)
    else $error("port a registered read late");
  a_rd_b_direct: assert property (rd_b ##1 !out_reg_b |=> valid_b)
    else $error("port b bypass read late");
  a_rd_b_reg: assert property (rd_b ##2 out_reg_b |=> valid_b)
    else $error("port b registered read late");
  a_valid_a_cause: assert property (valid_a |->
    ($past(rd_a, 2) && !$past(out_reg_a))
    || ($past(rd_a, 3) && $past(out_reg_a)))
    else $error("port a valid without read");
  a_cfg_mask: assert property (cfg_load [*4] |-> !valid_a && !valid_b)
    else $error("read answered during preload");
  a_single_mask: assert property (
    mode == embedded_block_ram_pkg::MODE_SINGLE [*4] |-> !valid_b)
    else $error("port b active in single mode");
  a_pseudo_mask: assert property (
    mode == embedded_block_ram_pkg::MODE_PSEUDO_DUAL [*4] |-> !valid_a)
    else $error("port a read in pseudo dual");
  a_dout_hold: assert property (!valid_a |-> $stable(dout_a))
    else $error("port a data moved without read");

  c_reg_a: cover property (rd_a && out_reg_a);
  c_dir_b: cover property (rd_b && !out_reg_b);
  c_load: cover property (cfg_load ##1 !cfg_load);
endmodule

bind embedded_block_ram ram_props i_props (
  .core_clk(core_clk), .reset(reset), .mode(mode),
  .out_reg_a(out_reg_a), .out_reg_b(out_reg_b), .cfg_load(cfg_load),
  .port_a(port_a), .port_b(port_b), .dout_a(dout_a),
  .valid_a(valid_a), .valid_b(valid_b));

// ===== verif/preload_user.sv
// fabric user logic that preloads the array at configuration
`timescale 1ns/1ps
`include "embedded_block_ram_defines.svh"

module preload_user (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire logic                              start,
  output      logic                              cfg_load,
  output      embedded_block_ram_pkg::init_req_s init,
  output      logic                              done
);
  function automatic logic [35:0] pat(input logic [7:0] i);
    return {4'h9, i, ~i, i ^ 8'h5a, i + 8'h33};
  endfunction

  initial begin
    cfg_load = 1'b0;
    init = '0;
    done = 1'b0;
  end

  // one word a cycle; idle data inverted so stale words never match
  always @(posedge core_clk) begin
    if (reset) begin
      cfg_load <= 1'b0;
      init <= '0;
      done <= 1'b0;
    end else if (start && !cfg_load && !done) begin
      cfg_load <= 1'b1;
      init <= '{1'b1, 8'h00, pat(8'h00)};
    end else if (cfg_load && init.addr == 8'hff) begin
      cfg_load <= 1'b0;
      init <= '{1'b0, 8'h00, ~init.data};
      done <= 1'b1;
    end else if (cfg_load) begin
      init <= '{1'b1, init.addr + 8'h01, pat(init.addr + 8'h01)};
    end
  end
endmodule

// ===== verif/test_embedded_block_ram.sv
// self-checking bench for the block ram tile
`timescale 1ns/1ps
`include "embedded_block_ram_defines.svh"

module test_embedded_block_ram;
  logic                              core_clk, reset, start, cfg_load;
  logic                              out_reg_a, out_reg_b, done;
  logic                              valid_a, valid_b;
  logic [`DATA_W-1:0]                dout_a, dout_b;
  embedded_block_ram_pkg::mode_e     mode;
  embedded_block_ram_pkg::width_e    width_a, width_b;
  embedded_block_ram_pkg::init_req_s init;
  embedded_block_ram_pkg::port_req_s port_a, port_b;
  int                                fails, check_count;
  bit                                mem [`ARRAY_BITS];
  int                                wtab [6] = '{1, 2, 4, 9, 18, 36};

  embedded_block_ram i_dut (.core_clk(core_clk), .reset(reset),
    .mode(mode), .width_a(width_a), .width_b(width_b),
    .out_reg_a(out_reg_a), .out_reg_b(out_reg_b), .cfg_load(cfg_load),
    .init(init), .port_a(port_a), .port_b(port_b), .dout_a(dout_a),
    .valid_a(valid_a), .dout_b(dout_b), .valid_b(valid_b));
  preload_user i_user (.core_clk(core_clk), .reset(reset), .start(start),
    .cfg_load(cfg_load), .init(init), .done(done));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic int dep(input int b);
    return b < 9 ? 8192 / b : 9216 / b;
  endfunction

  task automatic chk(input string n, input logic [35:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cfg(input embedded_block_ram_pkg::mode_e m,
    input int wa, wb, input logic oa, ob);
    @(posedge core_clk);
    mode <= m;
    width_a <= embedded_block_ram_pkg::width_e'(wa);
    width_b <= embedded_block_ram_pkg::width_e'(wb);
    out_reg_a <= oa;
    out_reg_b <= ob;
    // let the new shape settle before the model reads it
    #1;
  endtask

  // eff low: the request must be refused without trace
  task automatic op(input int p, input logic we, input int a,
    input logic [35:0] d, input bit eff);
    int b;
    logic [35:0] e;
    logic v;
    b = wtab[p ? width_b : width_a];
    // true dual has no 256x36 shape
    if (mode == embedded_block_ram_pkg::MODE_TRUE_DUAL && b == 36)
      b = 18;
    e = '0;
    for (int i = 0; i < b; i++) e[i] = mem[a * b + i];
    if (we && eff) for (int i = 0; i < b; i++) mem[a * b + i] = d[i];
    @(posedge core_clk);
    if (p) port_b <= '{we, !we, a[12:0], d};
    else port_a <= '{we, !we, a[12:0], d};
    @(posedge core_clk);
    port_a <= '0;
    port_b <= '0;
    v = 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      #1;
      if ((p ? valid_b : valid_a) === 1'b1 && !v) begin
        v = 1'b1;
        chk("dout", p ? dout_b : dout_a, e);
      end
    end
    chk("valid", 36'(v), 36'(!we && eff));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] k;
    int a, wa, wb, p, bp;
    void'($urandom(32'h8eb6));
    fails = 0;
    check_count = 0;
    {reset, start, out_reg_a, out_reg_b} = 4'h8;
    mode = embedded_block_ram_pkg::MODE_SINGLE;
    width_a = embedded_block_ram_pkg::W36;
    width_b = embedded_block_ram_pkg::W36;
    {port_a, port_b} = '0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      k = i[7:0];
      for (int j = 0; j < 36; j++)
        mem[i * 36 + j] = {4'h9, k, ~k, k ^ 8'h5a, k + 8'h33} >> j;
    end
    start <= 1'b1;
    repeat (300) if (done !== 1'b1) @(posedge core_clk);
    start <= 1'b0;
    // preloaded words read back as rom, writes held low
    cfg(embedded_block_ram_pkg::MODE_SINGLE, 5, 5, $urandom % 2, 0);
    repeat (8) op(0, 0, $urandom % 256, 0, 1);
    $display("test rom done");
    // mixed widths across write and read ports
    repeat (40) begin
      wa = $urandom % 6;
      wb = $urandom % 6;
      cfg(embedded_block_ram_pkg::MODE_PSEUDO_DUAL, wa, wb, 0, $urandom % 2);
      a = $urandom % dep(wtab[wa]);
      op(0, 1, a, 36'({$urandom, $urandom}), 1);
      bp = a * wtab[wa] / wtab[wb] % dep(wtab[wb]);
      op(1, 1, bp, 36'($urandom), 0);
      op(0, 0, a, 0, 0);
      op(1, 0, bp, 0, 1);
    end
    $display("test pseudo dual done");
    repeat (20) begin
      wa = $urandom % 6;
      wb = $urandom % 6;
      p = $urandom % 2;
      cfg(embedded_block_ram_pkg::MODE_TRUE_DUAL, wa, wb,
        $urandom % 2, $urandom % 2);
      a = $urandom % dep(wtab[p ? wb : wa]);
      op(p, 1, a, 36'({$urandom, $urandom}), 1);
      bp = a * wtab[p ? wb : wa] / wtab[p ? wa : wb];
      op(1 - p, 0, bp % dep(wtab[p ? wa : wb]), 0, 1);
    end
    $display("test true dual done");
    cfg(embedded_block_ram_pkg::MODE_SINGLE, 3, 3, 0, 0);
    op(1, 0, 5, 0, 0);
    op(1, 1, 5, 36'h1ff, 0);
    op(0, 0, 5, 0, 1);
    $display("test single port done");
    // reset clears the pipelines but must leave the array contents alone
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("dout", dout_a, '0);
    chk("valid", 36'(valid_a), '0);
    @(posedge core_clk);
    reset <= 1'b0;
    op(0, 0, 7, 0, 1);
    $display("test reset done");
    final_report;
  end

  // generous bound, the tests need about 1400 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    final_report;
  end
endmodule
